/* File: inc/lps_pkg.sv */
// constants, register map and state types for the light/reflect sensing block
// Functional notes
// - 12-bit light conversion every 100ms when enabled
// - light result readable at 0x9 and 0xA
// - 8-bit reflect result stored at 0x8
// - reflect result is lit minus dark reading
// - one reflect measurement lasts 0.54ms
// - LED pulsed 0.1ms per reflect measurement
// - sleep between measurements set by config[6:4]
// - config bit 3 selects LED drive strength
// - mode bit selects visible or infrared light
// - light and reflect converters run independently
// - light flag set outside programmed threshold window
// - light flag holds until host writes 0
// - reflect flag set above high threshold, persisted
// - reflect flag cleared below low, or host
// - persistence counts gate each flag separately
// - combine bit selects AND or OR of flags
// - both enables low means power-down
// - interrupt control register layout, resets to 0x00
package lps_pkg;
    localparam logic [7:0] REG_ID = 8'h00;
    localparam logic [7:0] REG_CFG = 8'h01;
    localparam logic [7:0] REG_INT = 8'h02;
    localparam logic [7:0] REG_PLT = 8'h03;
    localparam logic [7:0] REG_PHT = 8'h04;
    localparam logic [7:0] REG_LTA = 8'h05;
    localparam logic [7:0] REG_LTB = 8'h06;
    localparam logic [7:0] REG_LTC = 8'h07;
    localparam logic [7:0] REG_PRES = 8'h08;
    localparam logic [7:0] REG_LRES1 = 8'h09;
    localparam logic [7:0] REG_LRES2 = 8'h0a;
    localparam logic [7:0] REG_TE = 8'h0e;
    localparam logic [7:0] REG_TF = 8'h0f;
    localparam logic [7:0] REG_LAST = 8'h0f;
    localparam logic [7:0] REG_RST = 8'h00;
    // identity values are arbitrary
    localparam logic [7:0] ID_VALUE = 8'h5a;
    localparam logic [6:0] DEV_ID = 7'h3a;
    localparam int CFG_REN_BIT = 7;
    localparam int CFG_SLP_LSB = 4;
    localparam int CFG_DRV_BIT = 3;
    localparam int CFG_LEN_BIT = 2;
    localparam int CFG_MODE_BIT = 0;
    localparam int INT_RF_BIT = 7;
    localparam int INT_RP_LSB = 5;
    localparam int INT_LF_BIT = 3;
    localparam int INT_LP_LSB = 1;
    localparam int INT_COMB_BIT = 0;
    localparam logic [4:0] PERSIST_N0 = 5'h01;
    localparam logic [4:0] PERSIST_N1 = 5'h04;
    localparam logic [4:0] PERSIST_N2 = 5'h08;
    localparam logic [4:0] PERSIST_N3 = 5'h10;
    localparam int CLK_HZ = 10_000_000;
    localparam int LIGHT_CONV_MS = 100;
    localparam int PROX_CONV_US = 540;
    localparam int LED_PULSE_US = 100;
    localparam int SLEEP_STEP_US = 100;
    localparam int LIGHT_CONV_CYC = CLK_HZ / 1000 * LIGHT_CONV_MS;
    localparam int PROX_CONV_CYC = CLK_HZ / 1_000_000 * PROX_CONV_US;
    localparam int LED_PULSE_CYC = CLK_HZ / 1_000_000 * LED_PULSE_US;
    localparam int SLEEP_STEP_CYC = CLK_HZ / 1_000_000 * SLEEP_STEP_US;
    localparam int CW = 24;
    typedef enum logic [1:0] {PX_OFF, PX_MEAS, PX_SLEEP} lps_px_state_e;
    typedef enum logic [2:0] {BS_IDLE, BS_DEV, BS_REG, BS_WR, BS_RD} lps_bus_state_e;
endpackage : lps_pkg

/* File: rtl/lps_sense_top.sv */
// light and reflect sequencing, result registers, flags and interrupt pin
`timescale 1ns/1ps
module lps_sense_top #(
    parameter int LIGHT_CONV_CYC = lps_pkg::LIGHT_CONV_CYC,
    parameter int PROX_CONV_CYC = lps_pkg::PROX_CONV_CYC,
    parameter int SLEEP_STEP_CYC = lps_pkg::SLEEP_STEP_CYC,
    parameter int LED_PULSE_CYC = lps_pkg::LED_PULSE_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic [11:0] light_sample,
    input wire logic [7:0] ir_sample,
    output logic led_drive_pin,
    output logic led_drive_high,
    output logic light_ir_mode,
    output logic power_down,
    output logic interrupt_out_n
);
    localparam logic [23:0] LT_LAST = 24'(LIGHT_CONV_CYC - 1);
    localparam logic [23:0] PX_LAST = 24'(PROX_CONV_CYC - 1);
    localparam logic [23:0] LED_ON_AT = 24'(LED_PULSE_CYC);
    localparam logic [23:0] LED_OFF_AT = 24'(2 * LED_PULSE_CYC);
    localparam logic [23:0] LED_W = 24'(LED_PULSE_CYC);

    logic wr_en;
    logic [7:0] reg_addr, wr_data;
    logic [7:0] rd_data_w;
    logic [7:0] reg_view [0:15];

    logic [7:0] cfg_r, plt_r, pht_r, tha_r, thb_r, thc_r, te_r, tf_r;
    logic [1:0] rp_r, lp_r;
    logic comb_r;
    logic light_flag_r, reflect_flag_r;
    logic [11:0] light_result_r;
    logic [7:0] prox_result_r;

    logic [23:0] lt_cnt_r, px_cnt_r;
    lps_pkg::lps_px_state_e px_st_r;
    logic [7:0] dark_r, lit_r;
    logic led_r, led_high_r, mode_r, pdn_r, int_n_r;
    logic [4:0] lt_run_r, ph_run_r, pl_run_r;
    logic [23:0] led_width_r;

    function automatic logic [4:0] persist_need(input logic [1:0] code);
        persist_need = (code == 2'h0) ? lps_pkg::PERSIST_N0 :
                       (code == 2'h1) ? lps_pkg::PERSIST_N1 :
                       (code == 2'h2) ? lps_pkg::PERSIST_N2 : lps_pkg::PERSIST_N3;
    endfunction : persist_need

    // saturates at sixteen so a long run never wraps back under the limit
    function automatic logic [4:0] persist_step(input logic [4:0] cnt, input logic hit);
        persist_step = !hit ? 5'h00 : (cnt == lps_pkg::PERSIST_N3) ? cnt : cnt + 5'h01;
    endfunction : persist_step

    lps_serial_slave #(
        .DEV_ID(lps_pkg::DEV_ID)
    ) u_slave (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe_n(sda_oe_n),
        .wr_en(wr_en),
        .reg_addr(reg_addr),
        .wr_data(wr_data),
        .rd_data(rd_data_w)
    );

    // register decode
    wire wr_cfg_w = wr_en && reg_addr == lps_pkg::REG_CFG;
    wire wr_int_w = wr_en && reg_addr == lps_pkg::REG_INT;
    wire wr_plt_w = wr_en && reg_addr == lps_pkg::REG_PLT;
    wire wr_pht_w = wr_en && reg_addr == lps_pkg::REG_PHT;
    wire wr_lta_w = wr_en && reg_addr == lps_pkg::REG_LTA;
    wire wr_ltb_w = wr_en && reg_addr == lps_pkg::REG_LTB;
    wire wr_ltc_w = wr_en && reg_addr == lps_pkg::REG_LTC;
    wire wr_te_w = wr_en && reg_addr == lps_pkg::REG_TE;
    wire wr_tf_w = wr_en && reg_addr == lps_pkg::REG_TF;

    wire ren_w = cfg_r[lps_pkg::CFG_REN_BIT];
    wire len_w = cfg_r[lps_pkg::CFG_LEN_BIT];
    wire [2:0] slp_w = cfg_r[lps_pkg::CFG_SLP_LSB +: 3];
    wire [11:0] lt_low_w = {tha_r, thb_r[7:4]};
    wire [11:0] lt_high_w = {thb_r[3:0], thc_r};

    // read view, reserved bits and holes read as zero, except config bit 1 which reads back as written
    assign reg_view[0] = lps_pkg::ID_VALUE;
    assign reg_view[1] = cfg_r;
    assign reg_view[2] = {reflect_flag_r, rp_r, 1'b0, light_flag_r, lp_r, comb_r};
    assign reg_view[3] = plt_r;
    assign reg_view[4] = pht_r;
    assign reg_view[5] = tha_r;
    assign reg_view[6] = thb_r;
    assign reg_view[7] = thc_r;
    assign reg_view[8] = prox_result_r;
    assign reg_view[9] = light_result_r[7:0];
    assign reg_view[10] = {4'h0, light_result_r[11:8]};
    assign reg_view[11] = 8'h00;
    assign reg_view[12] = 8'h00;
    assign reg_view[13] = 8'h00;
    assign reg_view[14] = te_r;
    assign reg_view[15] = tf_r;
    assign rd_data_w = (reg_addr[7:4] == 4'h0) ? reg_view[reg_addr[3:0]] : 8'h00;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cfg_r <= lps_pkg::REG_RST;
            plt_r <= lps_pkg::REG_RST;
            pht_r <= lps_pkg::REG_RST;
            tha_r <= lps_pkg::REG_RST;
            thb_r <= lps_pkg::REG_RST;
            thc_r <= lps_pkg::REG_RST;
            te_r <= lps_pkg::REG_RST;
            tf_r <= lps_pkg::REG_RST;
            rp_r <= 2'h0;
            lp_r <= 2'h0;
            comb_r <= 1'b0;
        end else begin
            if (wr_cfg_w) cfg_r <= wr_data;
            if (wr_plt_w) plt_r <= wr_data;
            if (wr_pht_w) pht_r <= wr_data;
            if (wr_lta_w) tha_r <= wr_data;
            if (wr_ltb_w) thb_r <= wr_data;
            if (wr_ltc_w) thc_r <= wr_data;
            if (wr_te_w) te_r <= wr_data;
            if (wr_tf_w) tf_r <= wr_data;
            if (wr_int_w) begin
                rp_r <= wr_data[lps_pkg::INT_RP_LSB +: 2];
                lp_r <= wr_data[lps_pkg::INT_LP_LSB +: 2];
                comb_r <= wr_data[lps_pkg::INT_COMB_BIT];
            end
        end
    end

    // light converter: free running integration period while enabled
    wire lt_done_w = len_w && lt_cnt_r == LT_LAST;
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !len_w) lt_cnt_r <= 24'h0;
        else lt_cnt_r <= lt_done_w ? 24'h0 : lt_cnt_r + 24'h1;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) light_result_r <= 12'h000;
        else if (lt_done_w) light_result_r <= light_sample;
    end

    // reflect measurement: dark sample, LED pulse, lit sample, then sleep
    wire [23:0] sleep_len_w = 24'(SLEEP_STEP_CYC) * {21'h0, 3'h7 - slp_w};
    wire px_done_w = ren_w && px_st_r == lps_pkg::PX_MEAS && px_cnt_r == PX_LAST;
    wire [7:0] diff_w = (lit_r > dark_r) ? lit_r - dark_r : 8'h00;

    always_ff @(posedge sys_clk) begin
        if (!rst_n || !ren_w) begin
            px_st_r <= lps_pkg::PX_OFF;
            px_cnt_r <= 24'h0;
            led_r <= 1'b0;
        end else begin
            unique case (px_st_r)
                lps_pkg::PX_OFF: begin
                    px_st_r <= lps_pkg::PX_MEAS;
                    px_cnt_r <= 24'h0;
                end
                lps_pkg::PX_MEAS: begin
                    px_cnt_r <= px_cnt_r + 24'h1;
                    if (px_cnt_r == LED_ON_AT) led_r <= 1'b1;
                    if (px_cnt_r == LED_OFF_AT) led_r <= 1'b0;
                    if (px_done_w) begin
                        px_cnt_r <= 24'h0;
                        if (sleep_len_w != 24'h0) px_st_r <= lps_pkg::PX_SLEEP;
                    end
                end
                lps_pkg::PX_SLEEP: begin
                    px_cnt_r <= px_cnt_r + 24'h1;
                    if (px_cnt_r == sleep_len_w - 24'h1) begin
                        px_cnt_r <= 24'h0;
                        px_st_r <= lps_pkg::PX_MEAS;
                    end
                end
                default: px_st_r <= lps_pkg::PX_OFF;
            endcase
        end
    end

    // sample points sit on the LED edges so ambient drift between them is small
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            dark_r <= 8'h00;
            lit_r <= 8'h00;
            prox_result_r <= 8'h00;
        end else begin
            if (px_st_r == lps_pkg::PX_MEAS && px_cnt_r == LED_ON_AT) dark_r <= ir_sample;
            if (px_st_r == lps_pkg::PX_MEAS && px_cnt_r == LED_OFF_AT) lit_r <= ir_sample;
            if (px_done_w) prox_result_r <= diff_w;
        end
    end

    // window and threshold tests with persistence
    wire lt_out_w = light_sample < lt_low_w || light_sample > lt_high_w;
    wire [4:0] lt_run_nxt = persist_step(lt_run_r, lt_out_w);
    wire lt_set_w = lt_done_w && lt_out_w && lt_run_nxt >= persist_need(lp_r);
    wire ph_hit_w = diff_w > pht_r;
    wire pl_hit_w = diff_w < plt_r;
    wire [4:0] ph_run_nxt = persist_step(ph_run_r, ph_hit_w);
    wire [4:0] pl_run_nxt = persist_step(pl_run_r, pl_hit_w);
    wire rf_set_w = px_done_w && ph_hit_w && ph_run_nxt >= persist_need(rp_r);
    wire rf_lo_w = px_done_w && pl_hit_w && pl_run_nxt >= persist_need(rp_r);
    wire lf_clr_w = wr_int_w && !wr_data[lps_pkg::INT_LF_BIT];
    wire rf_clr_w = (wr_int_w && !wr_data[lps_pkg::INT_RF_BIT]) || rf_lo_w;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            lt_run_r <= 5'h00;
            ph_run_r <= 5'h00;
            pl_run_r <= 5'h00;
        end else begin
            if (lt_done_w) lt_run_r <= lt_run_nxt;
            if (px_done_w) ph_run_r <= ph_run_nxt;
            if (px_done_w) pl_run_r <= pl_run_nxt;
        end
    end

    // a set in the same cycle as a clear wins
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            light_flag_r <= 1'b0;
            reflect_flag_r <= 1'b0;
        end else begin
            light_flag_r <= lt_set_w || (light_flag_r && !lf_clr_w);
            reflect_flag_r <= rf_set_w || (reflect_flag_r && !rf_clr_w);
        end
    end

    wire comb_flag_w = comb_r ? (light_flag_r && reflect_flag_r) :
                                (light_flag_r || reflect_flag_r);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            int_n_r <= 1'b1;
            led_high_r <= 1'b0;
            mode_r <= 1'b0;
            pdn_r <= 1'b1;
            led_width_r <= 24'h0;
        end else begin
            int_n_r <= !comb_flag_w;
            led_high_r <= cfg_r[lps_pkg::CFG_DRV_BIT];
            mode_r <= cfg_r[lps_pkg::CFG_MODE_BIT];
            pdn_r <= !ren_w && !len_w;
            led_width_r <= led_r ? led_width_r + 24'h1 : 24'h0;
        end
    end

    assign led_drive_pin = led_r;
    assign led_drive_high = led_high_r;
    assign light_ir_mode = mode_r;
    assign power_down = pdn_r;
    assign interrupt_out_n = int_n_r;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // a pulse cut short by clearing the enable is legal, so only full ends count
    sequence led_ends_s;
        $fell(led_r) && ren_w;
    endsequence

    led_pulse_len_a: assert property (led_ends_s |-> led_width_r == LED_W)
        else $error("led pulse width wrong");

    prox_diff_a: assert property (px_done_w |=> prox_result_r == $past(diff_w))
        else $error("reflect result not lit minus dark");

    light_store_a: assert property (lt_done_w |=> light_result_r == $past(light_sample))
        else $error("light result not stored");

    light_period_a: assert property (lt_done_w |=> !lt_done_w [*8])
        else $error("light conversions too close");

    light_window_a: assert property (lt_done_w && lt_out_w && lp_r == 2'h0 |=> light_flag_r)
        else $error("light flag not set outside window");

    light_flag_hold_a: assert property (light_flag_r && !lf_clr_w |=> light_flag_r)
        else $error("light flag dropped without host clear");

    reflect_clear_a: assert property (px_done_w && pl_hit_w && !ph_hit_w && rp_r == 2'h0
        |=> !reflect_flag_r)
        else $error("reflect flag not cleared below low threshold");

    int_either_a: assert property (!comb_r && (light_flag_r || reflect_flag_r)
        |=> !interrupt_out_n)
        else $error("interrupt not asserted for either flag");

    int_release_a: assert property (comb_r && !(light_flag_r && reflect_flag_r)
        |=> interrupt_out_n)
        else $error("interrupt not released");

    power_down_a: assert property (!ren_w && !len_w |=> power_down && !led_drive_pin)
        else $error("power-down not entered");
endmodule : lps_sense_top

/* File: rtl/lps_serial_slave.sv */
// two-wire serial register slave with burst read and write
`timescale 1ns/1ps
module lps_serial_slave #(
    parameter logic [6:0] DEV_ID = lps_pkg::DEV_ID
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic wr_en,
    output logic [7:0] reg_addr,
    output logic [7:0] wr_data,
    input wire logic [7:0] rd_data
);
    logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
    lps_pkg::lps_bus_state_e st_r;
    logic [3:0] bit_r;
    logic [7:0] sh_r, ptr_r, wr_data_r;
    logic rw_r, mack_r, oe_n_r, wr_en_r;

    function automatic logic [7:0] ptr_next(input logic [7:0] p);
        ptr_next = (p == lps_pkg::REG_LAST) ? 8'h00 : p + 8'h01;
    endfunction : ptr_next

    // third stage only feeds the edge detectors
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            {scl_m, scl_s, scl_d} <= 3'h7;
            {sda_m, sda_s, sda_d} <= 3'h7;
        end else begin
            {scl_m, scl_s, scl_d} <= {scl_in, scl_m, scl_s};
            {sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
        end
    end

    wire start_w = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_w = scl_s & scl_d & ~sda_d & sda_s;
    wire rise_w = scl_s & ~scl_d;
    wire fall_w = ~scl_s & scl_d;
    wire id_ok_w = (sh_r[7:1] == DEV_ID);
    wire load_w = (st_r == lps_pkg::BS_DEV && rw_r) || (st_r == lps_pkg::BS_RD && mack_r);

    // a stop mid-byte simply drops the byte: writes happen only at the ack
    always_ff @(posedge sys_clk) begin
        wr_en_r <= 1'b0;
        if (!rst_n) begin
            st_r <= lps_pkg::BS_IDLE;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            ptr_r <= 8'h00;
            wr_data_r <= 8'h00;
            rw_r <= 1'b0;
            mack_r <= 1'b0;
            oe_n_r <= 1'b1;
        end else if (start_w) begin
            st_r <= lps_pkg::BS_DEV;
            bit_r <= 4'h0;
            oe_n_r <= 1'b1;
        end else if (stop_w) begin
            st_r <= lps_pkg::BS_IDLE;
            oe_n_r <= 1'b1;
        end else if (st_r != lps_pkg::BS_IDLE && rise_w) begin
            bit_r <= bit_r + 4'h1;
            if (bit_r < 4'h8 && st_r != lps_pkg::BS_RD) sh_r <= {sh_r[6:0], sda_s};
            if (bit_r == 4'h8 && st_r == lps_pkg::BS_RD) begin
                mack_r <= ~sda_s;
                if (!sda_s) ptr_r <= ptr_next(ptr_r);
            end
        end else if (st_r != lps_pkg::BS_IDLE && fall_w) begin
            if (bit_r == 4'h8) begin
                oe_n_r <= (st_r == lps_pkg::BS_RD) || (st_r == lps_pkg::BS_DEV && !id_ok_w);
                if (st_r == lps_pkg::BS_DEV) rw_r <= sh_r[0];
                if (st_r == lps_pkg::BS_DEV && !id_ok_w) st_r <= lps_pkg::BS_IDLE;
                if (st_r == lps_pkg::BS_REG) ptr_r <= sh_r;
                if (st_r == lps_pkg::BS_WR) begin
                    wr_en_r <= 1'b1;
                    wr_data_r <= sh_r;
                end
            end else if (bit_r == 4'h9) begin
                bit_r <= 4'h0;
                oe_n_r <= load_w ? rd_data[7] : 1'b1;
                if (load_w) sh_r <= {rd_data[6:0], 1'b0};
                unique case (st_r)
                    lps_pkg::BS_IDLE: ;
                    lps_pkg::BS_DEV: st_r <= rw_r ? lps_pkg::BS_RD : lps_pkg::BS_REG;
                    lps_pkg::BS_REG: st_r <= lps_pkg::BS_WR;
                    lps_pkg::BS_WR: ptr_r <= ptr_next(ptr_r);
                    lps_pkg::BS_RD: if (!mack_r) st_r <= lps_pkg::BS_IDLE;
                endcase
            end else if (st_r == lps_pkg::BS_RD) begin
                oe_n_r <= sh_r[7];
                sh_r <= {sh_r[6:0], 1'b0};
            end
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_n = oe_n_r;
    assign wr_en = wr_en_r;
    assign reg_addr = ptr_r;
    assign wr_data = wr_data_r;
endmodule : lps_serial_slave

/* File: test/light_proximity_sense_interrupt_tb.sv */
// self-checking bench for the light and reflect sensing block
`timescale 1ns/1ps
module light_proximity_sense_interrupt_tb;
    localparam int LC = 40;
    localparam int PC = 30;
    localparam int LP = 5;
    localparam int SS = 4;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] light_sample = 12'h000;
    logic [7:0] ir_sample = 8'h00;
    logic scl, sda_pull, sda_out, sda_oe_n, led_drive_pin, led_drive_high;
    logic light_ir_mode, power_down, interrupt_out_n;
    logic led_q = 1'b0;
    logic [7:0] rdv;
    int bad_count = 0;
    int compares = 0;
    int rises = 0;
    int gap = 0;
    int hi = 0;
    int per = 0;
    // pull-up on the data line; either party may pull it low
    wire sda_line = (sda_oe_n | sda_out) & ~sda_pull;
    always #50 sys_clk = ~sys_clk;
    lps_sense_top #(.LIGHT_CONV_CYC(LC), .PROX_CONV_CYC(PC), .SLEEP_STEP_CYC(SS),
        .LED_PULSE_CYC(LP)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .light_sample(light_sample), .ir_sample(ir_sample), .led_drive_pin(led_drive_pin),
        .led_drive_high(led_drive_high), .light_ir_mode(light_ir_mode),
        .power_down(power_down), .interrupt_out_n(interrupt_out_n));
    lps_host_model host (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl),
        .sda_pull(sda_pull));
    // reflected level follows the LED, so lit minus dark is 0x60
    always @(posedge sys_clk) begin
        #1;
        ir_sample = led_drive_pin ? 8'h70 : 8'h10;
    end
    always @(posedge sys_clk) begin
        led_q <= led_drive_pin;
        gap <= gap + 1;
        if (led_drive_pin) hi <= hi + 1;
        if (led_drive_pin && !led_q) begin
            rises <= rises + 1;
            per <= gap;
            gap <= 1;
            hi <= 1;
        end
    end
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task rd(input logic [7:0] a, input logic [7:0] exp);
        host.read_reg(a, rdv);
        chk(rdv, exp);
    endtask : rd
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc
    task wait_rises(input int n);
        int k;
        k = 0;
        while (rises < n && k < 4000) begin
            @(posedge sys_clk);
            k++;
        end
        #1;
        if (k >= 4000) chk(16'(rises), 16'(n));
    endtask : wait_rises
    task wrap_up;
        if (bad_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up
    task t_reset;
        chk(power_down, 1'b1);
        chk(interrupt_out_n, 1'b1);
        rd(lps_pkg::REG_INT, 8'h00);
    endtask : t_reset
    task t_recover;
        host.write_reg(lps_pkg::REG_CFG, 8'h00);
        host.write_reg(lps_pkg::REG_TF, 8'h29);
        host.write_reg(lps_pkg::REG_TE, 8'h00);
        host.write_reg(lps_pkg::REG_TF, 8'h00);
        cyc(10000);
        rd(lps_pkg::REG_TF, 8'h00);
    endtask : t_recover
    task t_light;
        light_sample = 12'habc;
        host.write_reg(lps_pkg::REG_LTA, 8'h10);
        host.write_reg(lps_pkg::REG_LTB, 8'h02);
        host.write_reg(lps_pkg::REG_LTC, 8'h00);
        host.write_reg(lps_pkg::REG_CFG, 8'h05);
        cyc(2 * LC);
        chk(light_ir_mode, 1'b1);
        chk(led_drive_high, 1'b0);
        chk(power_down, 1'b0);
        chk(interrupt_out_n, 1'b0);
        rd(lps_pkg::REG_LRES1, 8'hbc);
        rd(lps_pkg::REG_LRES2, 8'h0a);
        rd(lps_pkg::REG_INT, 8'h08);
        light_sample = 12'h180;
        cyc(2 * LC);
        chk(interrupt_out_n, 1'b0);
        host.write_reg(lps_pkg::REG_INT, 8'h00);
        cyc(2);
        chk(interrupt_out_n, 1'b1);
        rd(lps_pkg::REG_INT, 8'h00);
    endtask : t_light
    task t_reflect;
        host.write_reg(lps_pkg::REG_INT, 8'h20);
        host.write_reg(lps_pkg::REG_PHT, 8'h40);
        host.write_reg(lps_pkg::REG_CFG, 8'hdc);
        wait_rises(2);
        light_sample = 12'h1c3;
        cyc(LP + 2);
        chk(16'(hi), 16'(LP));
        chk(16'(per), 16'(PC + 2 * SS));
        chk(led_drive_high, 1'b1);
        chk(light_ir_mode, 1'b0);
        wait_rises(4);
        chk(interrupt_out_n, 1'b1);
        wait_rises(5);
        chk(interrupt_out_n, 1'b0);
        rd(lps_pkg::REG_LRES1, 8'hc3);
        rd(lps_pkg::REG_PRES, 8'h60);
        rd(lps_pkg::REG_INT, 8'ha0);
        host.write_reg(lps_pkg::REG_INT, 8'ha1);
        chk(interrupt_out_n, 1'b1);
        host.write_reg(lps_pkg::REG_INT, 8'h80);
        chk(interrupt_out_n, 1'b0);
        host.write_reg(lps_pkg::REG_PHT, 8'hff);
        host.write_reg(lps_pkg::REG_PLT, 8'h80);
        cyc(4 * (PC + 2 * SS));
        chk(interrupt_out_n, 1'b1);
        rd(lps_pkg::REG_INT, 8'h00);
        host.write_reg(lps_pkg::REG_CFG, 8'h00);
        cyc(2);
        chk(power_down, 1'b1);
    endtask : t_reflect
    initial begin
        cyc(16);
        rst_n = 1'b1;
        cyc(4);
        t_reset;
        t_recover;
        t_light;
        t_reflect;
        chk(16'(host.nak_cnt), 16'h0000);
        wrap_up;
    end
    // about three times the expected run length
    initial begin
        repeat (90000) @(posedge sys_clk);
        bad_count++;
        wrap_up;
    end
endmodule : light_proximity_sense_interrupt_tb

/* File: test/lps_host_model.sv */
// host-side two-wire master model for the serial register port
`timescale 1ns/1ps
module lps_host_model (
    input wire logic sys_clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_pull
);
    int nak_cnt = 0;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // eight clocks a phase stays clear of the two-flop synchroniser lag
    task tick;
        repeat (8) @(posedge sys_clk);
        #1;
    endtask : tick
    task bit_io(input logic b, output logic s);
        sda_pull = ~b;
        tick;
        scl = 1'b1;
        tick;
        s = sda_line;
        scl = 1'b0;
        tick;
    endtask : bit_io
    // also serves as repeated start, since scl is low on entry there
    task start;
        sda_pull = 1'b0;
        tick;
        scl = 1'b1;
        tick;
        sda_pull = 1'b1;
        tick;
        scl = 1'b0;
        tick;
    endtask : start
    task stop;
        sda_pull = 1'b1;
        tick;
        scl = 1'b1;
        tick;
        sda_pull = 1'b0;
        tick;
    endtask : stop
    task send(input logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        if (s) nak_cnt++;
    endtask : send
    task recv(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, s);
    endtask : recv
    task write_reg(input logic [7:0] a, input logic [7:0] d);
        start;
        send({lps_pkg::DEV_ID, 1'b0});
        send(a);
        send(d);
        stop;
    endtask : write_reg
    task read_reg(input logic [7:0] a, output logic [7:0] d);
        start;
        send({lps_pkg::DEV_ID, 1'b0});
        send(a);
        start;
        send({lps_pkg::DEV_ID, 1'b1});
        recv(1'b1, d);
        stop;
    endtask : read_reg
endmodule : lps_host_model
